// ### hdl/spiev_port.sv
// serial port with four event flags, phase/polarity select and master rate divider
// assumes pins already synchronous to pclk; pad logic merges the enables into wires
`timescale 1ns/1ps
`default_nettype none
module spiev_port #(
    parameter int DIV_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe,
    input  wire logic              select_line_in,
    output logic                   select_line_out,
    output logic                   select_line_oe,
    output logic                   irq
);

    // software-visible state
    logic                  master_enable_reg, master_enable_next;
    logic                  cpha_reg, cpha_next;
    logic                  cpol_reg, cpol_next;
    logic                  block_enable_reg, block_enable_next;
    logic                  irq_en_reg, irq_en_next;
    logic [1:0]            mode_reg, mode_next;
    logic [DIV_W-1:0]      rate_reg, rate_next;
    logic                  done_reg, done_next;
    logic                  write_collision_flag_reg, write_collision_flag_next;
    logic                  mode_fault_flag_reg, mode_fault_flag_next;
    logic                  ovr_reg, ovr_next;
    // shifter and buffers
    logic [7:0]            txb_reg, txb_next;
    logic                  txb_full_reg, txb_full_next;
    logic [7:0]            tx_sh_reg, tx_sh_next;
    logic [7:0]            rx_sh_reg, rx_sh_next;
    logic [7:0]            rxb_reg, rxb_next;
    logic                  rx_full_reg, rx_full_next;
    logic                  sh_empty_reg, sh_empty_next;
    logic [2:0]            bit_cnt_reg, bit_cnt_next;
    logic [2:0]            slh_cnt_reg, slh_cnt_next;
    // master clock generator
    spiev_pkg::spiev_mstate_t mstate_reg, mstate_next;
    logic [DIV_W:0]        div_cnt_reg, div_cnt_next;
    logic [3:0]            edge_cnt_reg, edge_cnt_next;
    logic                  sck_act_reg, sck_act_next;
    // previous pin samples for edge detection
    logic                  sck_prev_reg;
    logic                  sel_prev_reg;
    // registered pin and bus outputs
    logic                  sck_out_next, sck_oe_next, mosi_out_next, mosi_oe_next;
    logic                  miso_out_next, miso_oe_next, sel_out_next, sel_oe_next, irq_next;
    logic [31:0]           prdata_next;
    logic                  pready_next, pslverr_next;

    // combinational helpers
    logic                  commit, wr_cfg, wr_ctrl, wr_data, wr_rate, rd_data;
    logic                  sel_fall, selected, slave_act, mst_edge;
    logic                  lead, trail, sample_ev, shift_ev, din, byte_done, busy;
    logic [7:0]            rx_word;
    logic [DIV_W:0]        half_reload;

    // offsets known to the block
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == spiev_pkg::CFG_OFS) || (a == spiev_pkg::CTRL_OFS) ||
                   (a == spiev_pkg::DATA_OFS) || (a == spiev_pkg::RATE_OFS);
    endfunction

    // assembled read value for an offset
    function automatic logic [31:0] rd_word(input logic [11:0] a);
        rd_word = 32'h0000_0000;
        case (a)
            spiev_pkg::CFG_OFS: begin
                rd_word[spiev_pkg::CFG_BUSY]  = busy;
                rd_word[spiev_pkg::CFG_MST]   = master_enable_reg;
                rd_word[spiev_pkg::CFG_CPHA]  = cpha_reg;
                rd_word[spiev_pkg::CFG_CPOL]  = cpol_reg;
                rd_word[spiev_pkg::CFG_SELD]  = ~sel_prev_reg;
                rd_word[spiev_pkg::CFG_SELIN] = select_line_in;
                rd_word[spiev_pkg::CFG_SHEMP] = sh_empty_reg | master_enable_reg;
                rd_word[spiev_pkg::CFG_RXEMP] = ~rx_full_reg | master_enable_reg;
            end
            spiev_pkg::CTRL_OFS: begin
                rd_word[spiev_pkg::CTRL_DONE] = done_reg;
                rd_word[spiev_pkg::CTRL_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
                rd_word[spiev_pkg::CTRL_MODE_FAULT_FLAG] = mode_fault_flag_reg;
                rd_word[spiev_pkg::CTRL_OVR]  = ovr_reg;
                rd_word[spiev_pkg::CTRL_MODE +: 2] = mode_reg;
                rd_word[spiev_pkg::CTRL_IEN]  = irq_en_reg;
                rd_word[spiev_pkg::CTRL_EN]   = block_enable_reg;
            end
            spiev_pkg::DATA_OFS: rd_word[7:0] = rxb_reg;
            spiev_pkg::RATE_OFS: rd_word[DIV_W-1:0] = rate_reg;
            default:             rd_word = 32'h0000_0000;
        endcase
    endfunction

    // apb slave: one wait state, so data and error come straight from flops
    always_comb begin
        commit       = psel & penable & pready;
        pready_next  = psel & penable & ~pready;
        prdata_next  = prdata;
        pslverr_next = 1'b0;
        if (psel & penable & ~pready) begin
            prdata_next  = pwrite ? 32'h0000_0000 : rd_word(paddr);
            pslverr_next = ~addr_hit(paddr);
        end
        wr_cfg  = commit & pwrite & (paddr == spiev_pkg::CFG_OFS);
        wr_ctrl = commit & pwrite & (paddr == spiev_pkg::CTRL_OFS);
        wr_data = commit & pwrite & (paddr == spiev_pkg::DATA_OFS);
        wr_rate = commit & pwrite & (paddr == spiev_pkg::RATE_OFS);
        rd_data = commit & ~pwrite & (paddr == spiev_pkg::DATA_OFS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= pready_next;
            prdata  <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

    // serial engine: software writes first, hardware events after so a set beats a clear
    always_comb begin
        master_enable_next = master_enable_reg;
        cpha_next          = cpha_reg;
        cpol_next          = cpol_reg;
        block_enable_next  = block_enable_reg;
        irq_en_next        = irq_en_reg;
        mode_next          = mode_reg;
        rate_next          = rate_reg;
        done_next          = done_reg;
        write_collision_flag_next          = write_collision_flag_reg;
        mode_fault_flag_next          = mode_fault_flag_reg;
        ovr_next           = ovr_reg;
        txb_next           = txb_reg;
        txb_full_next      = txb_full_reg;
        tx_sh_next         = tx_sh_reg;
        rx_sh_next         = rx_sh_reg;
        rxb_next           = rxb_reg;
        rx_full_next       = rx_full_reg;
        sh_empty_next      = sh_empty_reg;
        bit_cnt_next       = bit_cnt_reg;
        slh_cnt_next       = (slh_cnt_reg != 3'h0) ? slh_cnt_reg - 3'h1 : 3'h0;
        mstate_next        = mstate_reg;
        div_cnt_next       = div_cnt_reg;
        edge_cnt_next      = edge_cnt_reg;
        sck_act_next       = sck_act_reg;

        // R25 half-period of whole clocks, never under the floor
        // R9 divider only reaches the master clock generator
        half_reload = {1'b0, rate_reg} + (DIV_W + 1)'(spiev_pkg::MIN_HALF_CLK - 1);
        sel_fall  = sel_prev_reg & ~select_line_in;
        // R20 select-mode decides whether the line selects us
        selected  = (mode_reg == spiev_pkg::MODE_3W) ||
                    ((mode_reg == spiev_pkg::MODE_4WIN) && !select_line_in);
        slave_act = block_enable_reg & ~master_enable_reg & selected;
        // R10 one edge per half-period keeps the rate at or under half the clock
        mst_edge  = (mstate_reg == spiev_pkg::M_RUN) && (div_cnt_reg == '0);
        // R6 R12 leading edge leaves the polarity idle level; one pin sample per pclk
        if (master_enable_reg) begin
            lead  = mst_edge & ~sck_act_reg;
            trail = mst_edge & sck_act_reg;
        end else begin
            lead  = slave_act & ((sck_in ^ cpol_reg) & ~(sck_prev_reg ^ cpol_reg));
            trail = slave_act & (~(sck_in ^ cpol_reg) & (sck_prev_reg ^ cpol_reg));
        end
        // R6 R7 phase chooses the latch edge; the far end must use the same setting
        sample_ev = cpha_reg ? trail : lead;
        shift_ev  = cpha_reg ? lead : trail;
        din       = master_enable_reg ? miso_in : mosi_in;
        // R24 msb first: new bits enter at the bottom
        rx_word   = sample_ev ? {rx_sh_reg[6:0], din} : rx_sh_reg;
        // R21 slave byte ends on the eighth sampling edge
        byte_done = master_enable_reg ? (mst_edge && edge_cnt_reg == spiev_pkg::LAST_EDGE)
                                      : (sample_ev && bit_cnt_reg == spiev_pkg::LAST_BIT);
        busy      = (mstate_reg == spiev_pkg::M_RUN) || (slave_act && bit_cnt_reg != 3'h0);

        // R2 flags clear only by writing zero
        if (wr_ctrl) begin
            if (!pwdata[spiev_pkg::CTRL_DONE]) done_next = 1'b0;
            if (!pwdata[spiev_pkg::CTRL_WRITE_COLLISION_FLAG]) write_collision_flag_next = 1'b0;
            if (!pwdata[spiev_pkg::CTRL_MODE_FAULT_FLAG]) mode_fault_flag_next = 1'b0;
            if (!pwdata[spiev_pkg::CTRL_OVR])  ovr_next  = 1'b0;
            mode_next         = pwdata[spiev_pkg::CTRL_MODE +: 2];
            irq_en_next       = pwdata[spiev_pkg::CTRL_IEN];
            block_enable_next = pwdata[spiev_pkg::CTRL_EN];
        end
        if (wr_cfg) begin
            master_enable_next = pwdata[spiev_pkg::CFG_MST];
            cpha_next          = pwdata[spiev_pkg::CFG_CPHA];
            cpol_next          = pwdata[spiev_pkg::CFG_CPOL];
        end
        if (wr_rate) rate_next = pwdata[DIV_W-1:0];
        if (rd_data) rx_full_next = 1'b0;
        // R3 write into a still-full buffer is dropped
        if (wr_data) begin
            if (txb_full_reg) begin
                write_collision_flag_next = 1'b1;
            end else begin
                txb_next      = pwdata[7:0];
                txb_full_next = 1'b1;
            end
        end

        // master clock generator
        if (mstate_reg == spiev_pkg::M_RUN) begin
            if (mst_edge) begin
                div_cnt_next  = half_reload;
                sck_act_next  = ~sck_act_reg;
                edge_cnt_next = edge_cnt_reg + 4'h1;
            end else begin
                div_cnt_next = div_cnt_reg - (DIV_W + 1)'(1);
            end
        end
        if (sample_ev) begin
            rx_sh_next   = rx_word;
            bit_cnt_next = bit_cnt_reg + 3'h1;
        end
        // R24 shift out from the top; first leading edge of phase one holds the msb
        if (shift_ev && bit_cnt_reg != 3'h0) tx_sh_next = {tx_sh_reg[6:0], 1'b0};
        if (!master_enable_reg && (lead || trail)) sh_empty_next = 1'b0;

        // R1 every finished byte raises done
        if (byte_done) begin
            done_next     = 1'b1;
            sh_empty_next = 1'b1;
            mstate_next   = spiev_pkg::M_IDLE;
            sck_act_next  = 1'b0;
            // R19 phase-one slave waits before its output may change
            if (!master_enable_reg && cpha_reg) slh_cnt_next = spiev_pkg::SLH_WAIT;
            // R5 keep the unread byte, lose the new one
            if (!master_enable_reg && rx_full_next) begin
                ovr_next = 1'b1;
            end else begin
                rxb_next     = rx_word;
                rx_full_next = 1'b1;
            end
        end else if (sh_empty_reg && txb_full_reg && slh_cnt_reg == 3'h0 && block_enable_reg) begin
            // R22 empty shifter takes the buffer at once and a master starts
            tx_sh_next    = txb_reg;
            txb_full_next = 1'b0;
            sh_empty_next = 1'b0;
            if (master_enable_reg) begin
                mstate_next   = spiev_pkg::M_RUN;
                div_cnt_next  = half_reload;
                edge_cnt_next = 4'h0;
                sck_act_next  = 1'b0;
                bit_cnt_next  = 3'h0;
            end
        end
        if (wr_data && !txb_full_reg) txb_full_next = 1'b1;

        // R23 select falling restarts the slave bit count
        if (sel_fall && !master_enable_reg && mode_reg == spiev_pkg::MODE_4WIN) bit_cnt_next = 3'h0;
        // R4 another master took the bus: fault and back off
        if (sel_fall && block_enable_reg && master_enable_reg && mode_reg == spiev_pkg::MODE_4WIN) begin
            mode_fault_flag_next          = 1'b1;
            master_enable_next = 1'b0;
            block_enable_next  = 1'b0;
        end
        // disabled block drops any transfer; a three-wire slave's bit count only restarts here
        if (!block_enable_next || master_enable_next != master_enable_reg) begin
            mstate_next   = spiev_pkg::M_IDLE;
            sck_act_next  = 1'b0;
            bit_cnt_next  = 3'h0;
            slh_cnt_next  = 3'h0;
            sh_empty_next = 1'b1;
        end

        // pins come from flops; R15 R16 output enable follows select within one clock
        sck_out_next  = sck_act_next ^ cpol_next;
        sck_oe_next   = block_enable_next & master_enable_next;
        mosi_out_next = tx_sh_next[7];
        mosi_oe_next  = block_enable_next & master_enable_next;
        miso_out_next = tx_sh_next[7];
        miso_oe_next  = block_enable_next & ~master_enable_next & selected;
        sel_out_next  = mode_next[0];
        sel_oe_next   = block_enable_next & mode_next[1];
        // R2 any set flag requests service when enabled
        irq_next      = irq_en_next & (done_next | write_collision_flag_next | mode_fault_flag_next | ovr_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_enable_reg <= 1'b0;
            cpha_reg          <= 1'b0;
            cpol_reg          <= 1'b0;
            block_enable_reg  <= 1'b0;
            irq_en_reg        <= 1'b0;
            mode_reg          <= spiev_pkg::MODE_RST;
            rate_reg          <= spiev_pkg::RATE_RST[DIV_W-1:0];
            done_reg          <= 1'b0;
            write_collision_flag_reg          <= 1'b0;
            mode_fault_flag_reg          <= 1'b0;
            ovr_reg           <= 1'b0;
            txb_reg           <= 8'h00;
            txb_full_reg      <= 1'b0;
            tx_sh_reg         <= 8'h00;
            rx_sh_reg         <= 8'h00;
            rxb_reg           <= 8'h00;
            rx_full_reg       <= 1'b0;
            sh_empty_reg      <= 1'b1;
            bit_cnt_reg       <= 3'h0;
            slh_cnt_reg       <= 3'h0;
            mstate_reg        <= spiev_pkg::M_IDLE;
            div_cnt_reg       <= '0;
            edge_cnt_reg      <= 4'h0;
            sck_act_reg       <= 1'b0;
            sck_prev_reg      <= 1'b0;
            sel_prev_reg      <= 1'b1;
            sck_out           <= 1'b0;
            sck_oe            <= 1'b0;
            mosi_out          <= 1'b0;
            mosi_oe           <= 1'b0;
            miso_out          <= 1'b0;
            miso_oe           <= 1'b0;
            select_line_out   <= 1'b1;
            select_line_oe    <= 1'b0;
            irq               <= 1'b0;
        end else begin
            master_enable_reg <= master_enable_next;
            cpha_reg          <= cpha_next;
            cpol_reg          <= cpol_next;
            block_enable_reg  <= block_enable_next;
            irq_en_reg        <= irq_en_next;
            mode_reg          <= mode_next;
            rate_reg          <= rate_next;
            done_reg          <= done_next;
            write_collision_flag_reg          <= write_collision_flag_next;
            mode_fault_flag_reg          <= mode_fault_flag_next;
            ovr_reg           <= ovr_next;
            txb_reg           <= txb_next;
            txb_full_reg      <= txb_full_next;
            tx_sh_reg         <= tx_sh_next;
            rx_sh_reg         <= rx_sh_next;
            rxb_reg           <= rxb_next;
            rx_full_reg       <= rx_full_next;
            sh_empty_reg      <= sh_empty_next;
            bit_cnt_reg       <= bit_cnt_next;
            slh_cnt_reg       <= slh_cnt_next;
            mstate_reg        <= mstate_next;
            div_cnt_reg       <= div_cnt_next;
            edge_cnt_reg      <= edge_cnt_next;
            sck_act_reg       <= sck_act_next;
            sck_prev_reg      <= sck_in;
            sel_prev_reg      <= select_line_in;
            sck_out           <= sck_out_next;
            sck_oe            <= sck_oe_next;
            mosi_out          <= mosi_out_next;
            mosi_oe           <= mosi_oe_next;
            miso_out          <= miso_out_next;
            miso_oe           <= miso_oe_next;
            select_line_out   <= sel_out_next;
            select_line_oe    <= sel_oe_next;
            irq               <= irq_next;
        end
    end

endmodule // spiev_port
`default_nettype wire

// ### hdl/spiev_pkg.sv
// constants, register map and state type of the serial port block
// assumes an apb master in front and a remote serial master or slave on the pins
// Function
// R1: transfer-done flag sets at the end of every byte, master or slave.
// R2: four event flags raise the interrupt when enabled; only software clears them.
// R3: data write with full transmit buffer is dropped and sets write collision.
// R4: select low in multi-master mode: mode fault, master and block disabled.
// R5: slave byte done with unread receive byte: overrun, old byte kept.
// R6: phase bit picks latch edge, polarity bit picks idle clock level.
// R7: both ends of the link use the same phase and polarity.
// R8: software disables the block before changing phase or polarity.
// R9: clock-rate divider shapes the serial clock in master mode only.
// R10: master bit rate never above half the system clock or 12.5 MHz.
// R11: remote master keeps full-duplex rate at or below a tenth of clock.
// R12: receive-only slave accepts bits up to a quarter of system clock.
// R13: remote master drives select low two clocks before first edge.
// R14: remote master waits two clocks after last edge before raising select.
// R15: selected slave drives valid output within four clocks of select falling.
// R16: slave releases output within four clocks of select rising.
// R17: remote master holds slave input stable two clocks before sampling.
// R18: remote master holds slave input two clocks after sampling edge.
// R19: slave with phase one changes output six to eight clocks after byte.
// R20: select-mode field: 00 three-wire, 01 slave/multi-master, 1x drive low bit.
// R21: slave counts clock edges; after eight bits copies byte and sets done.
// R22: master data write fills transmit buffer, moves on and starts when empty.
// R23: four-wire slave resets bit counter on each select falling edge.
// R24: bytes shift most significant bit first in both directions.
// R25: master half-period is whole clocks, at least one, from divider.
package spiev_pkg;

    // register byte offsets
    localparam logic [11:0] CFG_OFS  = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h004;
    localparam logic [11:0] DATA_OFS = 12'h008;
    localparam logic [11:0] RATE_OFS = 12'h00C;

    // configuration register fields
    localparam int CFG_BUSY   = 7;
    localparam int CFG_MST    = 6;
    localparam int CFG_CPHA   = 5;
    localparam int CFG_CPOL   = 4;
    localparam int CFG_SELD   = 3;
    localparam int CFG_SELIN  = 2;
    localparam int CFG_SHEMP  = 1;
    localparam int CFG_RXEMP  = 0;

    // control register fields
    localparam int CTRL_DONE  = 7;
    localparam int CTRL_WRITE_COLLISION_FLAG  = 6;
    localparam int CTRL_MODE_FAULT_FLAG  = 5;
    localparam int CTRL_OVR   = 4;
    localparam int CTRL_MODE  = 2;
    localparam int CTRL_IEN   = 1;
    localparam int CTRL_EN    = 0;

    // values after reset
    localparam logic [1:0] MODE_RST = 2'h1;
    localparam logic [7:0] RATE_RST = 8'h00;

    // select-mode encodings
    localparam logic [1:0] MODE_3W   = 2'h0;
    localparam logic [1:0] MODE_4WIN = 2'h1;

    // timing: clock rate, master rate ceiling, slave turn-around after a byte
    localparam longint SYSCLK_HZ    = 25000000;
    localparam longint MST_MAX_HZ   = 12500000;
    localparam int     MIN_HALF_CLK = int'((SYSCLK_HZ + 2 * MST_MAX_HZ - 1) / (2 * MST_MAX_HZ)) < 1 ? 1 :
                                      int'((SYSCLK_HZ + 2 * MST_MAX_HZ - 1) / (2 * MST_MAX_HZ));
    localparam int     SLH_MIN_CLK  = 6;
    localparam int     SLH_MAX_CLK  = 8;
    localparam logic [2:0] SLH_WAIT = 3'((SLH_MIN_CLK + SLH_MAX_CLK) / 2);
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [2:0] LAST_BIT  = 3'h7;

    typedef enum logic {M_IDLE, M_RUN} spiev_mstate_t;

endpackage

// ### tb/spiev_port_assertions.sv
// apb handshake and pin timing checks for the serial port
// assumes the single pclk domain of spiev_port; bound below
`timescale 1ns/1ps
`default_nettype none
module spiev_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sck_oe,
    input wire logic        mosi_oe,
    input wire logic        miso_oe,
    input wire logic        select_line_in,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_access: assert property (psel && penable && !pready |=> pready) else $error("late answer");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_hold: assert property ($changed(prdata) |-> pready) else $error("prdata moved");
    // flags only drop after a software write, and irq falls on the same edge as they do
    a_irq_holds: assert property (irq && !(psel && pwrite) && !($past(psel) && $past(pwrite)) |=> irq)
        else $error("irq fell by itself");
    a_miso_release: assert property ($rose(select_line_in) |-> ##[1:4] !miso_oe) else $error("miso held");
    a_fault_stop: assert property ($fell(select_line_in) && sck_oe |-> ##[1:3] !sck_oe)
        else $error("master kept bus");
    a_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe) else $error("master pin enables");
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_fault: cover property ($fell(select_line_in) && sck_oe);
endmodule // spiev_chk
bind spiev_port spiev_chk u_chk (.*);
`default_nettype wire

// ### tb/spiev_remote.sv
// remote slave on the link: echoes the byte it took in the frame before
// assumes the block is master with phase 0 and polarity 0
`timescale 1ns/1ps
`default_nettype none
module spiev_remote (
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0] sh_reg = 8'hA5; // first answer, known to the bench
    logic       bit_reg = 1'b0;
    // sample on rising, shift on falling, msb first
    always @(posedge sck) bit_reg <= mosi;
    always @(negedge sck) sh_reg <= {sh_reg[6:0], bit_reg};
    assign miso = sh_reg[7];
endmodule // spiev_remote
`default_nettype wire

// ### tb/tb_spi_port_events_and_clocking.sv
// bench: registers over apb, master transfers to an echoing remote, mode fault
// assumes spiev_pkg offsets and a remote slave in phase 0, polarity 0
`timescale 1ns/1ps
`default_nettype none
module tb_spi_port_events_and_clocking;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel = 1, err, sck_m = 0, mosi_m = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [7:0] b0, b1, got;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sel_out, sel_oe, irq, miso_r;
    // released clock and mosi come from the bench as remote master (idle low, pulled high)
    wire logic sck = sck_oe ? sck_out : sck_m;
    wire logic mosi = mosi_oe ? mosi_out : mosi_m;
    wire logic miso = miso_oe ? miso_out : miso_r;
    wire logic sel_w = sel_oe ? sel_out : sel;
    int fails = 0, n_checks = 0;
    spiev_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe), .select_line_in(sel_w),
        .select_line_out(sel_out), .select_line_oe(sel_oe), .irq(irq));
    spiev_remote far (.sck(sck), .mosi(mosi), .miso(miso_r));
    always #20 pclk = ~pclk;
    task automatic chk(logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // request held until pready is seen at a rising edge
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // bench as remote master: five pclk per sck level, msb first
    task automatic slv_byte(logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            mosi_m <= v[i];
            repeat (5) @(posedge pclk);
            got = {got[6:0], miso};
            sck_m <= 1'b1;
            repeat (5) @(posedge pclk);
            sck_m <= 1'b0;
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin apb(0, spiev_pkg::CTRL_OFS, 0); n++; end while (rd[7] !== 1'b1 && n < 100);
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #2ms;
        fails++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hFBAE));
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, spiev_pkg::CTRL_OFS, 0); chk(rd, 32'h4);
        apb(0, spiev_pkg::CFG_OFS, 0); chk(rd, 32'h7);
        apb(0, 12'h010, 0); chk(err, 1);
        // three-wire master, irq on; third write hits a full buffer
        apb(1, spiev_pkg::CFG_OFS, 32'h40);
        apb(1, spiev_pkg::CTRL_OFS, 32'h3);
        apb(1, spiev_pkg::RATE_OFS, $urandom_range(3));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        apb(1, spiev_pkg::DATA_OFS, b0);
        apb(1, spiev_pkg::DATA_OFS, b1);
        apb(1, spiev_pkg::DATA_OFS, ~b1);
        wait_done(); chk(rd, 32'hC3);
        chk(irq, 1);
        apb(1, spiev_pkg::CTRL_OFS, 32'h3);
        apb(0, spiev_pkg::DATA_OFS, 0); chk(rd, 32'hA5);
        chk(irq, 0);
        wait_done(); chk(rd, 32'h83);
        apb(0, spiev_pkg::DATA_OFS, 0); chk(rd, {24'h0, b0});
        // multi-master: select pulled low as the master loads its byte, before the clock starts
        apb(1, spiev_pkg::CTRL_OFS, 32'h5);
        apb(1, spiev_pkg::DATA_OFS, b1);
        sel <= 0;
        repeat (2) @(posedge pclk);
        apb(0, spiev_pkg::CTRL_OFS, 0); chk(rd, 32'h24);
        apb(0, spiev_pkg::CFG_OFS, 0); chk(rd[6], 0);
        sel <= 1;
        repeat (6) @(posedge pclk);
        // select-mode 10 drives the select pin low from the mode field while the master bit stays clear
        apb(1, spiev_pkg::CTRL_OFS, 32'h9);
        apb(0, spiev_pkg::CFG_OFS, 0); chk(rd, 32'hB);
        // selected slave: first byte echoes the preload, second one overruns
        apb(1, spiev_pkg::CTRL_OFS, 32'h5);
        apb(1, spiev_pkg::DATA_OFS, {24'h0, b1});
        sel <= 0;
        repeat (2) @(posedge pclk);
        slv_byte(b0); chk(got, b1);
        slv_byte(b1);
        repeat (2) @(posedge pclk);
        sel <= 1;
        apb(0, spiev_pkg::CTRL_OFS, 0); chk(rd, 32'h95);
        apb(0, spiev_pkg::DATA_OFS, 0); chk(rd, {24'h0, b0});
        report_and_stop();
    end
endmodule // tb_spi_port_events_and_clocking
`default_nettype wire
